/* cmo_maint.sv */
// cache maintenance sequencer with register port and way locking
// Function
// - way operations run in the background
// - unlock all lines also runs in background
// - write starts op on ways set
// - way bit cleared when way finished
// - several ways may be selected together
// - eight-way build reserves bits 15 to 8
// - control writes during background get slave error
// - targeted ways blocked from allocation
// - hits still serviced during background work
// - sync completes when all buffers empty
// - invalidate line clears valid, no writeback
// - invalidate way discards all lines, even dirty
// - clean line writes back, clears dirty only
// - clean way writes back dirty lines
// - clean invalidate line writes back then invalidates
// - clean invalidate way writes back, invalidates all
// - non-secure tag bit kept unchanged
// - line ops stall, read shows c flag
// - non-secure way ops skip secure lines
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module cmo_maint
   import cmo_pkg::*;
#(
   parameter int WAYS  = 16,
   parameter int IDX_W = 7,
   parameter bit LINE_LOCKDOWN = 1'b1
) (
   input  wire logic              i_core_clk,
   input  wire logic              i_nrst,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   input  wire logic              i_ns,
   output logic [DATA_W-1:0]      o_rdata,
   output logic                   o_slverr,
   output logic                   o_stall,
   input  wire logic              i_fill,
   input  wire logic              i_fill_ns,
   input  wire logic [IDX_W+3:0]  i_fill_addr,
   output logic [WAYS_MAX-1:0]    o_alloc_lock,
   output logic                   o_wb_valid,
   output logic [IDX_W+3:0]       o_wb_addr,
   input  wire logic              i_wb_ready,
   output logic                   o_unlock_lines,
   input  wire logic              i_unlock_done,
   input  wire logic              i_buf_empty,
   output logic                   o_drain_store
);
   localparam logic [WAY_SEL_W-1:0] WAY_MASK = WAY_SEL_W'((32'h1 << WAYS) - 1);

   cmo_tag_if #(.IDX_W(IDX_W), .WAY_W(4)) tag ();

   cmo_tag_mem #(.IDX_W(IDX_W), .WAY_W(4)) u_tag (
      .i_core_clk  (i_core_clk),
      .i_nrst      (i_nrst),
      .i_fill      (i_fill),
      .i_fill_ns   (i_fill_ns),
      .i_fill_addr (i_fill_addr),
      .tag         (tag.slave)
   );

   state_type             state_q;
   op_type                op_q;
   logic [WAY_SEL_W-1:0]  ways_q;
   logic [3:0]            way_q;
   logic [IDX_W-1:0]      idx_q;
   logic                  line_q;
   logic                  ns_q;
   logic                  bg_q;
   logic                  unlock_q;
   logic [DATA_W-1:0]     ctrl_q;
   logic [1:0]            err_q;
   logic [DATA_W-1:0]     rdata_q;
   logic                  slverr_q;
   logic                  stall_q;
   logic [WAYS_MAX-1:0]   lock_q;
   logic                  wb_valid_q;
   logic [IDX_W+3:0]      wb_addr_q;
   logic                  drain_q;

   // register decode
   wire sel_sync    = i_addr == OFS_SYNC;
   wire sel_inv_adr = i_addr == OFS_INV_ADR;
   wire sel_inv_way = i_addr == OFS_INV_WAY;
   wire sel_cln_adr = i_addr == OFS_CLN_ADR;
   wire sel_cln_idx = i_addr == OFS_CLN_IDX;
   wire sel_cln_way = i_addr == OFS_CLN_WAY;
   wire sel_ci_adr  = i_addr == OFS_CI_ADR;
   wire sel_ci_idx  = i_addr == OFS_CI_IDX;
   wire sel_ci_way  = i_addr == OFS_CI_WAY;
   wire sel_unlock  = LINE_LOCKDOWN && i_addr == OFS_UNLOCK_ALL;
   wire sel_ctrl    = i_addr == OFS_CTRL;
   wire sel_status  = i_addr == OFS_STATUS;
   wire sel_err     = i_addr == OFS_ERR;
   wire sel_way     = sel_inv_way | sel_cln_way | sel_ci_way;
   wire sel_line    = sel_inv_adr | sel_cln_adr | sel_cln_idx | sel_ci_adr | sel_ci_idx;
   wire sel_any     = sel_way | sel_line | sel_sync | sel_unlock | sel_ctrl | sel_status | sel_err;

   wire busy        = bg_q | unlock_q;
   wire idle        = state_q == ST_IDLE && !busy;
   wire wr_reject   = i_wr && busy && sel_any;
   wire wr_ok       = i_wr && idle;
   wire [WAY_SEL_W-1:0] wsel = i_wdata[WAY_SEL_LSB +: WAY_SEL_W] & WAY_MASK;
   wire start_way   = wr_ok && sel_way && wsel != '0;
   wire start_line  = wr_ok && sel_line;
   wire start_sync  = wr_ok && sel_sync;
   wire start_unl   = wr_ok && sel_unlock;

   wire op_is_inv   = sel_inv_way | sel_inv_adr;
   wire op_is_cln   = sel_cln_way | sel_cln_adr | sel_cln_idx;
   wire [IDX_W-1:0] wr_idx = i_wdata[ADR_INDEX_LSB +: IDX_W];
   wire [3:0]       wr_way = i_wdata[IDXWAY_WAY_LSB +: 4];
   wire             adr_op = sel_inv_adr | sel_cln_adr | sel_ci_adr;

   // lowest selected way
   logic [3:0] first_way;
   always_comb begin
      first_way = 4'h0;
      for (int i = WAY_SEL_W - 1; i >= 0; i--) begin
         if (ways_q[i]) begin
            first_way = 4'(i);
         end
      end
   end

   // line decision after tag read
   wire line_hit    = tag.rvalid && (!ns_q || tag.rns);
   wire need_wb     = line_hit && tag.rdirty && op_q != OP_INV;
   wire new_valid   = (op_q == OP_CLN) ? tag.rvalid : (tag.rvalid && !line_hit);
   wire new_dirty   = (op_q == OP_CLN) ? (tag.rdirty && !line_hit) : (tag.rdirty && !line_hit);
   wire last_idx    = idx_q == '1;
   wire way_done    = state_q == ST_WRITE && !line_q && last_idx;
   wire [WAY_SEL_W-1:0] way_bit = WAY_SEL_W'(1) << way_q;

   assign tag.rd     = state_q == ST_READ;
   assign tag.wr     = state_q == ST_WRITE;
   assign tag.idx    = idx_q;
   assign tag.way    = way_q;
   assign tag.wvalid = new_valid;
   assign tag.wdirty = new_dirty;

   // maintenance sequencer
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_q <= ST_IDLE;
         op_q    <= OP_INV;
         ways_q  <= '0;
         way_q   <= 4'h0;
         idx_q   <= '0;
         line_q  <= 1'b0;
         ns_q    <= 1'b0;
         bg_q    <= 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (start_way) begin
                  op_q   <= op_is_inv ? OP_INV : (op_is_cln ? OP_CLN : OP_CI);
                  ways_q <= wsel;
                  ns_q   <= i_ns;
                  line_q <= 1'b0;
                  bg_q   <= 1'b1;
                  idx_q  <= '0;
                  state_q <= ST_LOOK;
               end else if (start_line) begin
                  op_q   <= op_is_inv ? OP_INV : (op_is_cln ? OP_CLN : OP_CI);
                  idx_q  <= wr_idx;
                  way_q  <= adr_op ? 4'h0 : wr_way;
                  ns_q   <= i_ns;
                  line_q <= 1'b1;
                  state_q <= ST_READ;
               end else if (start_sync) begin
                  state_q <= ST_SYNC;
               end
            end
            ST_LOOK: begin
               if (ways_q == '0) begin
                  bg_q    <= 1'b0;
                  state_q <= ST_IDLE;
               end else begin
                  way_q   <= first_way;
                  idx_q   <= '0;
                  state_q <= ST_READ;
               end
            end
            ST_READ: begin
               state_q <= ST_WB;
            end
            ST_WB: begin
               if (!need_wb || (wb_valid_q && i_wb_ready)) begin
                  state_q <= ST_WRITE;
               end
            end
            ST_WRITE: begin
               if (line_q) begin
                  state_q <= ST_IDLE;
               end else if (last_idx) begin
                  ways_q  <= ways_q & ~way_bit;
                  state_q <= ST_LOOK;
               end else begin
                  idx_q   <= idx_q + 1'b1;
                  state_q <= ST_READ;
               end
            end
            ST_SYNC: begin
               if (i_buf_empty) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // write-back request to main memory level
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         wb_valid_q <= 1'b0;
         wb_addr_q  <= '0;
      end else if (wb_valid_q) begin
         wb_valid_q <= !i_wb_ready;
      end else if (state_q == ST_WB && need_wb) begin
         wb_valid_q <= 1'b1;
         wb_addr_q  <= {way_q, idx_q};
      end
   end

   // unlock all lines, background
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         unlock_q <= 1'b0;
      end else if (start_unl) begin
         unlock_q <= 1'b1;
      end else if (i_unlock_done) begin
         unlock_q <= 1'b0;
      end
   end

   // per-way allocation lock, released as each way finishes
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         lock_q <= '0;
      end else if (start_way) begin
         lock_q <= WAYS_MAX'(wsel);
      end else if (way_done) begin
         lock_q <= lock_q & ~WAYS_MAX'(way_bit);
      end
   end

   // bus stall during atomic ops, sync drain
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         stall_q <= 1'b0;
         drain_q <= 1'b0;
      end else begin
         stall_q <= start_line || start_sync || (!bg_q && state_q != ST_IDLE &&
                    !(state_q == ST_WRITE && line_q) && !(state_q == ST_SYNC && i_buf_empty));
         drain_q <= start_sync || (state_q == ST_SYNC && !i_buf_empty);
      end
   end

   // control and error registers
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ctrl_q   <= '0;
         err_q    <= 2'h0;
         slverr_q <= 1'b0;
      end else begin
         slverr_q <= wr_reject;
         if (wr_ok && sel_ctrl) begin
            ctrl_q <= i_wdata;
         end
         if (wr_reject) begin
            err_q[ERR_SLVERR] <= 1'b1;
         end else if (i_wr && sel_err && !busy) begin
            err_q <= err_q & ~i_wdata[1:0];
         end
         if ((i_wr || i_rd) && !sel_any) begin
            err_q[ERR_ADDR] <= 1'b1;
         end
      end
   end

   // read data, one cycle later
   wire [DATA_W-1:0] way_rd  = DATA_W'(ways_q);
   wire              c_flag  = busy;
   wire [DATA_W-1:0] rd_mux  =
      (sel_inv_way && op_q == OP_INV) ? way_rd :
      (sel_cln_way && op_q == OP_CLN) ? way_rd :
      (sel_ci_way  && op_q == OP_CI)  ? way_rd :
      (sel_line | sel_sync | sel_unlock) ? DATA_W'(c_flag) << C_FLAG_BIT :
      sel_ctrl   ? ctrl_q :
      sel_status ? DATA_W'({lock_q, 14'h0, unlock_q, bg_q}) :
      sel_err    ? DATA_W'(err_q) : '0;

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rdata_q <= '0;
      end else if (i_rd) begin
         rdata_q <= rd_mux;
      end else begin
         rdata_q <= '0;
      end
   end

   assign o_rdata        = rdata_q;
   assign o_slverr       = slverr_q;
   assign o_stall        = stall_q;
   assign o_alloc_lock   = lock_q;
   assign o_wb_valid     = wb_valid_q;
   assign o_wb_addr      = wb_addr_q;
   assign o_unlock_lines = unlock_q;
   assign o_drain_store  = drain_q;

   a_way_bits_clear: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      way_done |=> !ways_q[$past(way_q)]) else $error("way bit not cleared");
   a_bg_slverr: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (i_wr && bg_q && sel_ctrl) |=> o_slverr) else $error("no slave error in background");
   a_lock_start: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      start_way |=> o_alloc_lock == WAYS_MAX'($past(wsel))) else $error("ways not locked");
   a_lock_subset: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      bg_q |-> ((o_alloc_lock & ~WAYS_MAX'(ways_q)) == '0)) else $error("lock kept after way done");
   a_upper_reserved: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (ways_q & ~WAY_MASK) == '0) else $error("reserved way bit set");
   a_sync_wait: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (state_q == ST_SYNC && !i_buf_empty) |=> state_q == ST_SYNC) else $error("sync ended early");
   a_inv_no_wb: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (state_q == ST_WB && op_q == OP_INV) |=> !o_wb_valid) else $error("invalidate wrote back");
   a_bg_start: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      start_way |=> bg_q && !o_stall) else $error("way op not background");
   a_secure_skip: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
      (state_q == ST_WB && ns_q && !tag.rns) |-> !need_wb) else $error("secure line touched");
endmodule

/* cmo_maint_tb.sv */
// self-checking bench for the maintenance sequencer
`timescale 1ns/1ps
module cmo_maint_tb;
   import cmo_pkg::*;
   localparam int IW = 2;
   logic              i_core_clk = 1'b0;
   logic              i_nrst = 1'b0;
   logic [ADDR_W-1:0] i_addr = '0;
   logic [DATA_W-1:0] i_wdata = '0;
   logic              i_wr = 1'b0;
   logic              i_rd = 1'b0;
   logic              i_ns = 1'b0;
   logic              i_fill = 1'b0;
   logic              i_fill_ns = 1'b0;
   logic [IW+3:0]     i_fill_addr = '0;
   wire  [DATA_W-1:0] o_rdata;
   wire               o_slverr, o_stall, o_wb_valid, o_unlock_lines, o_drain_store;
   wire  [15:0]       o_alloc_lock;
   wire  [IW+3:0]     o_wb_addr, last_addr;
   wire               wb_ready, unlock_done, buf_empty;
   int                wb_count;
   int                fails = 0;
   int                cmp_count = 0;
   integer            seed = 89529;
   logic              lv[64], ld[64], lns[64];

   always #50 i_core_clk = ~i_core_clk;

   cmo_maint #(.WAYS(16), .IDX_W(IW), .LINE_LOCKDOWN(1'b1)) dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_ns(i_ns), .o_rdata(o_rdata),
      .o_slverr(o_slverr), .o_stall(o_stall), .i_fill(i_fill), .i_fill_ns(i_fill_ns),
      .i_fill_addr(i_fill_addr), .o_alloc_lock(o_alloc_lock), .o_wb_valid(o_wb_valid),
      .o_wb_addr(o_wb_addr), .i_wb_ready(wb_ready), .o_unlock_lines(o_unlock_lines),
      .i_unlock_done(unlock_done), .i_buf_empty(buf_empty), .o_drain_store(o_drain_store));

   cmo_mem_model #(.AW(IW+4), .BUSY(6)) mem (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
      .i_wb_valid(o_wb_valid), .i_wb_addr(o_wb_addr), .i_unlock_lines(o_unlock_lines),
      .i_drain_store(o_drain_store), .o_wb_ready(wb_ready), .o_unlock_done(unlock_done),
      .o_buf_empty(buf_empty), .o_last_addr(last_addr), .o_wb_count(wb_count));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t mismatch seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      if (fails == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic bus_wr(input logic [11:0] a, input logic [31:0] d, input logic ns, output logic err);
      @(posedge i_core_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_ns    <= ns;
      i_wr    <= 1'b1;
      @(posedge i_core_clk);
      i_wr    <= 1'b0;
      #1 err = o_slverr;
   endtask

   task automatic bus_rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge i_core_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_core_clk);
      i_rd   <= 1'b0;
      #1 d = o_rdata;
   endtask

   task automatic fill(input int k, input logic ns);
      @(posedge i_core_clk);
      i_fill      <= 1'b1;
      i_fill_ns   <= ns;
      i_fill_addr <= k[IW+3:0];
      @(posedge i_core_clk);
      i_fill      <= 1'b0;
      lv[k]  = 1'b1;
      ld[k]  = 1'b1;
      lns[k] = ns;
   endtask

   // lines a way operation must write back
   function automatic int exp_wb(input logic [15:0] ws, input logic nsr);
      int n = 0;
      for (int k = 0; k < 64; k++)
         if (ws[k>>IW] && lv[k] && ld[k] && (!nsr || lns[k])) n++;
      return n;
   endfunction

   task automatic way_op(input logic [2:0] op, input logic [15:0] ws, input logic nsr);
      logic [11:0] a;
      logic [31:0] d;
      logic        e;
      int          base;
      int          n;
      a    = (op == OP_INV) ? OFS_INV_WAY : (op == OP_CLN) ? OFS_CLN_WAY : OFS_CI_WAY;
      base = wb_count;
      n    = (op == OP_INV) ? 0 : exp_wb(ws, nsr);
      bus_wr(a, {16'h0, ws}, nsr, e);
      chk(e, 1'b0);
      @(posedge i_core_clk);
      #1 chk(o_alloc_lock, ws);
      bus_wr(OFS_CTRL, 32'h1, 1'b0, e);
      chk(e, 1'b1);
      bus_rd(OFS_CLN_IDX, d);
      chk(d[0], 1'b1);
      d = 32'hFFFF;
      for (int t = 0; t < 2000 && d[15:0] != 16'h0; t++)
         bus_rd(a, d);
      chk(d[15:0], 16'h0);
      chk(o_alloc_lock, 16'h0);
      chk(wb_count - base, n);
      for (int k = 0; k < 64; k++)
         if (ws[k>>IW] && (!nsr || lns[k])) begin
            if (op != OP_CLN) lv[k] = 1'b0;
            ld[k] = 1'b0;
         end
   endtask

   task automatic line_op(input logic [11:0] a, input int k);
      logic e;
      int   base;
      int   n;
      base = wb_count;
      n    = (a != OFS_INV_ADR && lv[k] && ld[k]) ? 1 : 0;
      bus_wr(a, {k[IW+3:IW], 21'h0, k[IW-1:0], 5'h0}, 1'b0, e);
      @(posedge i_core_clk);
      #1 chk(o_stall, 1'b1);
      for (int t = 0; t < 200 && o_stall !== 1'b0; t++) begin
         @(posedge i_core_clk);
         #1;
      end
      chk(wb_count - base, n);
      if (n == 1)
         chk(last_addr, k[IW+3:0]);
      if (a != OFS_CLN_ADR && a != OFS_CLN_IDX) lv[k] = 1'b0;
      ld[k] = 1'b0;
   endtask

   initial begin
      repeat (60000) @(posedge i_core_clk);
      fails++;
      complete_run();
   end

   initial begin
      logic [31:0] d;
      logic        e;
      logic [15:0] ws;
      logic [2:0]  ops[3];
      int          cnt;
      ops = '{OP_INV, OP_CLN, OP_CI};
      for (int k = 0; k < 64; k++) begin
         lv[k]  = 1'b0;
         ld[k]  = 1'b0;
         lns[k] = 1'b0;
      end
      repeat (8) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      chk({o_alloc_lock, o_stall, o_unlock_lines}, 32'h0);
      bus_rd(OFS_CLN_WAY, d);
      chk(d, 32'h0);
      bus_rd(12'h004, d);
      chk(d, 32'h0);
      bus_rd(OFS_ERR, d);
      chk(d[1], 1'b1);
      bus_wr(OFS_ERR, 32'h3, 1'b0, e);
      bus_rd(OFS_ERR, d);
      chk(d[1:0], 2'h0);
      // two ways at once, then again with nothing dirty left
      foreach (ops[i]) fill(i * 5, 1'b0);
      fill(6, 1'b1);
      way_op(OP_CLN, 16'h0003, 1'b0);
      way_op(OP_CLN, 16'h0003, 1'b0);
      // non-secure request leaves the secure line alone
      fill(8, 1'b0);
      fill(9, 1'b1);
      way_op(OP_CI, 16'h0004, 1'b1);
      way_op(OP_CLN, 16'h0004, 1'b0);
      fill(13, 1'b0);
      way_op(OP_INV, 16'hFFFF, 1'b0);
      way_op(OP_CLN, 16'hFFFF, 1'b0);
      fill(1, 1'b0);
      line_op(OFS_CLN_ADR, 1);
      line_op(OFS_CLN_ADR, 1);
      fill(6, 1'b0);
      line_op(OFS_CI_IDX, 6);
      line_op(OFS_CLN_IDX, 6);
      fill(2, 1'b0);
      line_op(OFS_INV_ADR, 2);
      line_op(OFS_CLN_IDX, 2);
      fill(7, 1'b0);
      fill(3, 1'b0);
      line_op(OFS_CLN_IDX, 7);
      line_op(OFS_CI_ADR, 3);
      // sync holds stall until the buffers drain
      bus_wr(OFS_SYNC, 32'h0, 1'b0, e);
      @(posedge i_core_clk);
      #1 chk({o_stall, o_drain_store}, 2'h3);
      cnt = 0;
      for (int t = 0; t < 200 && o_stall !== 1'b0; t++) begin
         @(posedge i_core_clk);
         #1;
         cnt++;
      end
      chk(cnt >= 5, 1'b1);
      chk(o_drain_store, 1'b0);
      // unlock of all lines runs in the background
      bus_wr(OFS_UNLOCK_ALL, 32'h0, 1'b0, e);
      @(posedge i_core_clk);
      #1 chk(o_unlock_lines, 1'b1);
      bus_wr(OFS_CTRL, 32'h1, 1'b0, e);
      chk(e, 1'b1);
      for (int t = 0; t < 100 && o_unlock_lines !== 1'b0; t++) begin
         @(posedge i_core_clk);
         #1;
      end
      bus_wr(OFS_CTRL, 32'h1, 1'b0, e);
      chk(e, 1'b0);
      for (int r = 0; r < 10; r++) begin
         repeat (5) fill(int'($unsigned($random(seed)) % 64), 1'($random(seed)));
         ws = 16'($random(seed));
         if (ws == 16'h0) ws = 16'h8001;
         way_op(ops[$unsigned($random(seed)) % 3], ws, 1'($random(seed)));
      end
      complete_run();
   end
endmodule

/* cmo_mem_model.sv */
// memory side model: write-back acceptor, line unlock engine and buffer state
`timescale 1ns/1ps
module cmo_mem_model #(
   parameter int AW   = 6,
   parameter int BUSY = 6
) (
   input  wire logic          i_core_clk,
   input  wire logic          i_nrst,
   input  wire logic          i_wb_valid,
   input  wire logic [AW-1:0] i_wb_addr,
   input  wire logic          i_unlock_lines,
   input  wire logic          i_drain_store,
   output logic               o_wb_ready,
   output logic               o_unlock_done,
   output logic               o_buf_empty,
   output logic [AW-1:0]      o_last_addr,
   output int                 o_wb_count
);
   logic [2:0] pace_q;
   int         busy_q;
   int         unl_q;

   // ready is one cycle wide, a cycle late when valid is first seen with pace_q[0] clear
   // each accepted write-back leaves BUSY cycles of store draining
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pace_q        <= 3'h0;
         busy_q        <= 0;
         unl_q         <= 0;
         o_wb_ready    <= 1'b0;
         o_unlock_done <= 1'b0;
         o_buf_empty   <= 1'b1;
         o_last_addr   <= '0;
         o_wb_count    <= 0;
      end else begin
         pace_q        <= pace_q + 3'h1;
         o_wb_ready    <= i_wb_valid && !o_wb_ready && pace_q[0];
         if (i_wb_valid && o_wb_ready) begin
            o_wb_count  <= o_wb_count + 1;
            o_last_addr <= i_wb_addr;
            busy_q      <= BUSY;
         end else if (i_drain_store && busy_q > 0) begin
            busy_q      <= busy_q - 1;
         end
         unl_q         <= i_unlock_lines ? unl_q + 1 : 0;
         o_unlock_done <= i_unlock_lines && unl_q == 4;
         o_buf_empty   <= busy_q == 0;
      end
   end
endmodule

/* cmo_pkg.sv */
// constants and types shared by the maintenance operation logic
package cmo_pkg;
   localparam int          ADDR_W         = 12;
   localparam int          DATA_W         = 32;
   localparam int          WAYS_MAX       = 16;
   localparam int          WAY_SEL_LSB    = 0;
   localparam int          WAY_SEL_W      = 16;
   localparam int          C_FLAG_BIT     = 0;
   localparam int          ADR_INDEX_LSB  = 5;
   localparam int          IDXWAY_WAY_LSB = 28;
   localparam logic [11:0] OFS_SYNC       = 12'h730;
   localparam logic [11:0] OFS_INV_ADR    = 12'h770;
   localparam logic [11:0] OFS_INV_WAY    = 12'h77C;
   localparam logic [11:0] OFS_CLN_ADR    = 12'h7B0;
   localparam logic [11:0] OFS_CLN_IDX    = 12'h7B8;
   localparam logic [11:0] OFS_CLN_WAY    = 12'h7BC;
   localparam logic [11:0] OFS_CI_ADR     = 12'h7F0;
   localparam logic [11:0] OFS_CI_IDX     = 12'h7F8;
   localparam logic [11:0] OFS_CI_WAY     = 12'h7FC;
   localparam logic [11:0] OFS_UNLOCK_ALL = 12'h954;
   localparam logic [11:0] OFS_CTRL       = 12'h100;
   localparam logic [11:0] OFS_STATUS     = 12'h104;
   localparam logic [11:0] OFS_ERR        = 12'h108;
   localparam int          CTRL_ENABLE    = 0;
   localparam int          ERR_SLVERR     = 0;
   localparam int          ERR_ADDR       = 1;

   typedef enum logic [2:0] {
      OP_INV = 3'h1,
      OP_CLN = 3'h2,
      OP_CI  = 3'h4
   } op_type;

   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_READ  = 6'h02,
      ST_LOOK  = 6'h04,
      ST_WB    = 6'h08,
      ST_WRITE = 6'h10,
      ST_SYNC  = 6'h20
   } state_type;
endpackage

/* cmo_tag_if.sv */
// tag ram access between the sequencer and the tag store
`timescale 1ns/1ps
interface cmo_tag_if #(parameter int IDX_W = 7, parameter int WAY_W = 4);
   logic             rd;
   logic             wr;
   logic [IDX_W-1:0] idx;
   logic [WAY_W-1:0] way;
   logic             wvalid;
   logic             wdirty;
   logic             rvalid;
   logic             rdirty;
   logic             rns;
   modport master (output rd, wr, idx, way, wvalid, wdirty, input rvalid, rdirty, rns);
   modport slave  (input rd, wr, idx, way, wvalid, wdirty, output rvalid, rdirty, rns);
endinterface

/* cmo_tag_mem.sv */
// line state memory: valid, dirty and non-secure bit per index and way
`timescale 1ns/1ps
module cmo_tag_mem #(
   parameter int IDX_W = 7,
   parameter int WAY_W = 4
) (
   input  wire logic  i_core_clk,
   input  wire logic  i_nrst,
   input  wire logic  i_fill,
   input  wire logic  i_fill_ns,
   input  wire logic [IDX_W+WAY_W-1:0] i_fill_addr,
   cmo_tag_if.slave   tag
);
   localparam int DEPTH = 1 << (IDX_W + WAY_W);
   logic [2:0] mem [DEPTH];
   logic [2:0] rd_q;
   wire  [IDX_W+WAY_W-1:0] addr = {tag.way, tag.idx};

   // ns bit is never altered by maintenance writes
   // every line starts invalid so a way walk never reads unknown state
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= 3'h0;
         end
      end else if (tag.wr) begin
         mem[addr] <= {mem[addr][2], tag.wdirty, tag.wvalid};
      end else if (i_fill) begin
         mem[i_fill_addr] <= {i_fill_ns, 1'b1, 1'b1};
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rd_q <= 3'h0;
      end else if (tag.rd) begin
         rd_q <= mem[addr];
      end
   end

   assign tag.rvalid = rd_q[0];
   assign tag.rdirty = rd_q[1];
   assign tag.rns    = rd_q[2];
endmodule
